// [rtl/swr_params.svh]
`ifndef SWR_PARAMS_SVH
`define SWR_PARAMS_SVH

// clock period in ns (50 MHz)
`define SWR_CLK_NS 20

// rom function command codes
`define SWR_CMD_READ_ID 8'h33
`define SWR_CMD_SELECT 8'h55
`define SWR_CMD_SEARCH 8'hF0
`define SWR_CMD_ALARM_SEARCH 8'hEC
`define SWR_CMD_SKIP 8'hCC
`define SWR_CMD_RESUME 8'hA5
`define SWR_CMD_FAST_SKIP 8'h3C
`define SWR_CMD_FAST_SELECT 8'h69

// register offsets and fields
`define SWR_ALARM_FLAGS_OFS 16'h0214
`define SWR_GENERAL_FLAGS_OFS 16'h0215
`define SWR_ALARM_MASK 8'h07
`define SWR_DISTURBED_BYTE 8'hFF
`define SWR_ID_BITS 64

// line timing in microseconds
`define SWR_T_RST_STD_US 120
`define SWR_T_RST_FAST_US 12
`define SWR_T_RST_LONG_US 690
`define SWR_T_PRES_WAIT_STD_US 15
`define SWR_T_PRES_WAIT_FAST_US 2
`define SWR_T_PRES_LOW_STD_US 60
`define SWR_T_PRES_LOW_FAST_US 8
`define SWR_T_SAMPLE_STD_US 30
`define SWR_T_SAMPLE_FAST_US 3
`define SWR_T_HOLD_STD_US 30
`define SWR_T_HOLD_FAST_US 3

// least times round up, longest times round down
`define SWR_CYC_UP(us) (((us) * 1000 + `SWR_CLK_NS - 1) / `SWR_CLK_NS)
`define SWR_CYC_DN(us) (((us) * 1000) / `SWR_CLK_NS)

`endif

// [rtl/swr_pkg.sv]
package swr_pkg;

  // rom layer sequencing
  typedef enum logic [2:0] {
    SWR_IDLE,
    SWR_ROM_CMD,
    SWR_READ_ID,
    SWR_SELECT,
    SWR_SEARCH,
    SWR_MEM
  } swr_state_e;

  // presence pulse phases
  typedef enum logic [1:0] {
    SWR_PRES_OFF,
    SWR_PRES_WAIT,
    SWR_PRES_LOW
  } swr_pres_e;

  // status seen from the logging core
  typedef struct packed {
    logic [7:0] alarm_flags;
    logic [7:0] general_flags;
    logic mission_running_flag;
    logic wait_alarm;
    logic sample_busy;
  } swr_status_s;

  // byte offered by the memory/control layer for read slots
  typedef struct packed {
    logic en;
    logic [7:0] data;
  } swr_tx_s;

  // whole state of the rom layer
  typedef struct packed {
    swr_state_e st;
    swr_pres_e pres;
    logic line_q;
    logic [15:0] low_cnt;
    logic [15:0] slot_cnt;
    logic [15:0] pres_cnt;
    logic in_slot;
    logic drive;
    logic od;
    logic rc;
    logic [6:0] bitcnt;
    logic [1:0] trip;
    logic [7:0] sh;
    logic [7:0] txsh;
    logic [7:0] push_data;
    logic push;
    logic tx_take;
    logic mem_active;
    logic link_reset;
    logic [7:0] general_view;
    logic refuse;
  } swr_core_s;

endpackage : swr_pkg

// [rtl/swr_rom_layer.sv]
`timescale 1ns/1ps
`include "swr_params.svh"

////////////////////////////////////////////////////////////////////////////////
// byte fifo between the link and the memory/control layer
module swr_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [W-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } swr_fifo_s;

  swr_fifo_s q;
  swr_fifo_s d;
  logic full;
  logic empty;

  // an extra pointer bit tells full from empty
  assign full = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
  assign empty = (q.wp == q.rp);
  assign in_ready_out = ~full;
  assign out_valid_out = ~empty;
  assign out_data_out = q.mem[q.rp[AW-1:0]];

  // push and pop may happen in the same cycle
  always_comb begin
    d = q;
    if (in_valid_in && !full) begin
      d.mem[q.wp[AW-1:0]] = in_data_in;
      d.wp = q.wp + 1'b1;
    end
    if (out_ready_in && !empty) begin
      d.rp = q.rp + 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : swr_fifo

////////////////////////////////////////////////////////////////////////////////
// Contract
// - during mission or alarm wait, sampling beats bus; rom commands and reset unaffected
// - mission start, forced conversion, clear are refused while mission runs or waits
// - disturbed scratchpad write closes with FFFFh instead of its crc
// - disturbed scratchpad or memory reads return FFh bytes, crc included
// - disturbed copy looks refused or endless; host checks copy accepted flag later
// - disturbed mission stop shows general flags as FFh
// - one master only; device is slave; slots start on master falling edges
// - line driven only open drain, forming a wired-and
// - low over 120us resets at standard speed, over 12us at fast speed
// - bit rates up to 15.4kbps standard and 125kbps fast are supported
// - order is reset, one rom command, one memory command, then data
// - master reset pulse is answered by a presence pulse
// - eight rom commands are accepted after presence, eight bits each
// - 33h sends family code, 48-bit serial and crc; single slave only
// - 55h compares 64 bits; match passes control, mismatch idles to reset
// - F0h sends bit, complement, then reads master bit, lsb first
// - a search slave that mismatches the written bit drops out until reset
// - ECh takes part only when one of three alarm flags reads 1
// - power-loss alarm always enabled; finished conditional pass leaves device selected
// - CCh passes straight to memory commands without comparison
// - A5h works only with resume flag; select or search sets, others clear (code clears it only on a select or search mismatch)
// - 3Ch sets fast speed until a reset of at least 690us
// - 69h with 64 fast bits selects a matching device in fast speed
module swr_rom_layer #(
  // arbitrary registration number, family code in the low byte
  parameter logic [63:0] REG_ID = 64'hA5C3_0123_4567_8910,
  parameter logic [15:0] RST_STD_CYC = 16'(`SWR_CYC_UP(`SWR_T_RST_STD_US)),
  parameter logic [15:0] RST_LONG_CYC = 16'(`SWR_CYC_UP(`SWR_T_RST_LONG_US))
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic line_in,
  output logic line_out,
  output logic line_oe_out,
  input wire swr_pkg::swr_status_s status_in,
  input wire swr_pkg::swr_tx_s mem_tx_in,
  output logic mem_tx_take_out,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  input wire logic rx_ready_in,
  output logic mem_active_out,
  output logic fast_speed_flag_out,
  output logic resume_allowed_flag_out,
  output logic link_reset_out,
  output logic [7:0] general_view_out,
  output logic refuse_out
);
  import swr_pkg::*;

  // timing in cycles for each speed
  localparam logic [15:0] RST_FAST_CYC = 16'(`SWR_CYC_UP(`SWR_T_RST_FAST_US));
  localparam logic [15:0] PW_STD = 16'(`SWR_CYC_UP(`SWR_T_PRES_WAIT_STD_US));
  localparam logic [15:0] PW_FAST = 16'(`SWR_CYC_UP(`SWR_T_PRES_WAIT_FAST_US));
  localparam logic [15:0] PL_STD = 16'(`SWR_CYC_UP(`SWR_T_PRES_LOW_STD_US));
  localparam logic [15:0] PL_FAST = 16'(`SWR_CYC_UP(`SWR_T_PRES_LOW_FAST_US));
  localparam logic [15:0] SMP_STD = 16'(`SWR_CYC_UP(`SWR_T_SAMPLE_STD_US));
  localparam logic [15:0] SMP_FAST = 16'(`SWR_CYC_UP(`SWR_T_SAMPLE_FAST_US));
  localparam logic [15:0] HLD_STD = 16'(`SWR_CYC_DN(`SWR_T_HOLD_STD_US));
  localparam logic [15:0] HLD_FAST = 16'(`SWR_CYC_DN(`SWR_T_HOLD_FAST_US));
  localparam logic [6:0] ID_LAST = 7'(`SWR_ID_BITS - 1);

  swr_core_s q;
  swr_core_s d;
  logic fifo_ready;
  logic fall;
  logic rise;
  logic [15:0] rst_cyc;
  logic [15:0] smp_cyc;
  logic [15:0] hld_cyc;
  logic id_bit;
  logic tx_need;
  logic tx_bit;
  logic [7:0] cmd_byte;
  logic [7:0] mem_byte;
  logic alarmed;

  //////////////////////////////////////////////////////////////////////////////
  // speed dependent windows; fast speed shortens every waveform
  always_comb begin
    rst_cyc = q.od ? RST_FAST_CYC : RST_STD_CYC;
    smp_cyc = q.od ? SMP_FAST : SMP_STD;
    hld_cyc = q.od ? HLD_FAST : HLD_STD;
  end

  // master edges; every slot begins on the master's falling edge
  assign fall = q.line_q & ~line_in;
  assign rise = ~q.line_q & line_in;
  assign id_bit = REG_ID[q.bitcnt[5:0]];
  assign cmd_byte = {line_in, q.sh[7:1]};
  assign mem_byte = {line_in, q.sh[7:1]};
  // the power-loss alarm is set by the core unconditionally, so any of the three low alarm flags counts
  assign alarmed = |(status_in.alarm_flags & `SWR_ALARM_MASK);

  //////////////////////////////////////////////////////////////////////////////
  // bit that goes out in a read slot and whether this state sends at all
  always_comb begin
    tx_need = 1'b0;
    tx_bit = 1'b1;
    unique case (q.st)
      SWR_READ_ID: begin
        tx_need = 1'b1;
        tx_bit = id_bit;
      end
      SWR_SEARCH: begin
        tx_need = (q.trip != 2'd2);
        tx_bit = (q.trip == 2'd0) ? id_bit : ~id_bit;
      end
      SWR_MEM: begin
        // sampling owns the core: read slots return ones, so bytes and crcs read FFh
        tx_need = mem_tx_in.en & ~status_in.sample_busy;
        tx_bit = (q.bitcnt[2:0] == 3'd0) ? mem_tx_in.data[0] : q.txsh[q.bitcnt[2:0]];
      end
      SWR_IDLE, SWR_ROM_CMD, SWR_SELECT: begin
        tx_need = 1'b0;
        tx_bit = 1'b1;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state: reset detection first, then presence, then slot engine
  always_comb begin
    d = q;
    d.line_q = line_in;
    d.push = 1'b0;
    d.tx_take = 1'b0;
    d.link_reset = 1'b0;
    // a disturbed stop must not report a stale flag set
    d.general_view = status_in.sample_busy ? `SWR_DISTURBED_BYTE
                                           : status_in.general_flags;
    d.refuse = status_in.mission_running_flag | status_in.wait_alarm;

    // low time counter; own presence drive does not count as a reset
    if (line_in || q.pres != SWR_PRES_OFF) begin
      d.low_cnt = 16'h0000;
    end else if (q.low_cnt != 16'hFFFF) begin
      d.low_cnt = q.low_cnt + 16'h0001;
    end

    if (rise && q.low_cnt >= rst_cyc) begin
      // bus reset always wins, whatever the sampling core is doing
      d.st = SWR_ROM_CMD;
      d.pres = SWR_PRES_WAIT;
      d.pres_cnt = 16'h0000;
      d.in_slot = 1'b0;
      d.drive = 1'b0;
      d.bitcnt = 7'h00;
      d.trip = 2'd0;
      d.link_reset = 1'b1;
      if (q.low_cnt >= RST_LONG_CYC) begin
        d.od = 1'b0;
      end
    end else if (q.pres == SWR_PRES_WAIT) begin
      d.pres_cnt = q.pres_cnt + 16'h0001;
      if (q.pres_cnt >= (q.od ? PW_FAST : PW_STD)) begin
        d.pres = SWR_PRES_LOW;
        d.pres_cnt = 16'h0000;
        d.drive = 1'b1;
      end
    end else if (q.pres == SWR_PRES_LOW) begin
      d.pres_cnt = q.pres_cnt + 16'h0001;
      if (q.pres_cnt >= (q.od ? PL_FAST : PL_STD)) begin
        d.pres = SWR_PRES_OFF;
        d.drive = 1'b0;
      end
    end else if (fall && !q.in_slot) begin
      // slot start; a zero is sent by pulling low at once
      d.in_slot = 1'b1;
      d.slot_cnt = 16'h0000;
      d.drive = tx_need & ~tx_bit;
      if (q.st == SWR_MEM && tx_need && q.bitcnt[2:0] == 3'd0) begin
        d.txsh = mem_tx_in.data;
        d.tx_take = 1'b1;
      end
    end else if (q.in_slot) begin
      d.slot_cnt = q.slot_cnt + 16'h0001;
      if (q.slot_cnt >= hld_cyc) begin
        d.drive = 1'b0;
      end
      if (q.slot_cnt == smp_cyc) begin
        // slot complete; line_in holds the master's bit for write slots
        d.in_slot = 1'b0;
        d.drive = 1'b0;
        unique case (q.st)
          SWR_ROM_CMD: begin
            d.sh = cmd_byte;
            d.bitcnt = q.bitcnt + 7'h01;
            if (q.bitcnt == 7'd7) begin
              // one eight-bit rom command per reset
              d.bitcnt = 7'h00;
              d.trip = 2'd0;
              unique case (cmd_byte)
                `SWR_CMD_READ_ID: d.st = SWR_READ_ID;
                `SWR_CMD_SELECT: d.st = SWR_SELECT;
                `SWR_CMD_FAST_SELECT: begin
                  d.st = SWR_SELECT;
                  d.od = 1'b1;
                  // the low still running began as a standard slot, not a fast reset
                  d.low_cnt = 16'h0000;
                end
                `SWR_CMD_SEARCH: d.st = SWR_SEARCH;
                `SWR_CMD_ALARM_SEARCH: d.st = alarmed ? SWR_SEARCH : SWR_IDLE;
                `SWR_CMD_SKIP: d.st = SWR_MEM;
                `SWR_CMD_FAST_SKIP: begin
                  d.st = SWR_MEM;
                  d.od = 1'b1;
                  d.low_cnt = 16'h0000;
                end
                `SWR_CMD_RESUME: d.st = q.rc ? SWR_MEM : SWR_IDLE;
                default: d.st = SWR_IDLE;
              endcase
            end
          end
          SWR_READ_ID: begin
            d.bitcnt = q.bitcnt + 7'h01;
            if (q.bitcnt == ID_LAST) begin
              d.bitcnt = 7'h00;
              d.st = SWR_MEM;
            end
          end
          SWR_SELECT: begin
            d.bitcnt = q.bitcnt + 7'h01;
            if (line_in != id_bit) begin
              // another device is being addressed
              d.st = SWR_IDLE;
              d.rc = 1'b0;
            end else if (q.bitcnt == ID_LAST) begin
              d.bitcnt = 7'h00;
              d.st = SWR_MEM;
              d.rc = 1'b1;
            end
          end
          SWR_SEARCH: begin
            if (q.trip != 2'd2) begin
              d.trip = q.trip + 2'd1;
            end else if (line_in != id_bit) begin
              d.st = SWR_IDLE;
              d.rc = 1'b0;
            end else begin
              d.trip = 2'd0;
              d.bitcnt = q.bitcnt + 7'h01;
              if (q.bitcnt == ID_LAST) begin
                // survivor of a full pass stays selected
                d.bitcnt = 7'h00;
                d.st = SWR_MEM;
                d.rc = 1'b1;
              end
            end
          end
          SWR_MEM: begin
            d.bitcnt = {4'h0, q.bitcnt[2:0] + 3'd1};
            if (!tx_need && !mem_tx_in.en) begin
              d.sh = mem_byte;
              if (q.bitcnt[2:0] == 3'd7) begin
                // the link cannot stall, so a full buffer ends the transaction
                if (fifo_ready) begin
                  d.push = 1'b1;
                  d.push_data = mem_byte;
                end else begin
                  d.st = SWR_IDLE;
                end
              end
            end
          end
          SWR_IDLE: begin
            d.st = SWR_IDLE; // waits for the next reset
          end
        endcase
      end
    end

    d.mem_active = (d.st == SWR_MEM);
  end

  //////////////////////////////////////////////////////////////////////////////
  // single state register; synchronous reset clears it except line_q (loaded 1) and general_view (loaded FFh)
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      q <= '0;
      q.line_q <= 1'b1;
      q.general_view <= `SWR_DISTURBED_BYTE;
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // received memory-phase bytes toward the memory/control layer
  swr_fifo #(
    .W(8),
    .D(16)
  ) u_rx_fifo (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .in_data_in(q.push_data),
    .in_valid_in(q.push),
    .in_ready_out(fifo_ready),
    .out_data_out(rx_data_out),
    .out_valid_out(rx_valid_out),
    .out_ready_in(rx_ready_in)
  );

  // open drain: only ever pulls low
  assign line_out = 1'b0;
  assign line_oe_out = q.drive;
  assign mem_tx_take_out = q.tx_take;
  assign mem_active_out = q.mem_active;
  assign fast_speed_flag_out = q.od;
  assign resume_allowed_flag_out = q.rc;
  assign link_reset_out = q.link_reset;
  assign general_view_out = q.general_view;
  assign refuse_out = q.refuse;
endmodule : swr_rom_layer

// [test/single_wire_rom_layer_bench.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module single_wire_rom_layer_bench;
  import swr_pkg::*;
  // arbitrary registration number
  localparam logic [63:0] ID = 64'h3C5A_9E01_2468_ACE0;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic m_low, dev_oe, bus_line, take, rx_valid, mem_act, fast, rc, lrst, refuse;
  logic rx_ready = 1'b0;
  logic line_lvl;
  int take_count = 0;
  logic [7:0] rx_data, gview;
  swr_status_s status = '0;
  swr_tx_s tx = '0;
  int fail_count = 0;
  int total_checks = 0;
  always #10 clk_in = ~clk_in;
  // wired-and of both pull-downs over the pull-up
  assign bus_line = !m_low && (!dev_oe || line_lvl);
  // a byte handed to the link shows as a one-cycle take pulse
  always @(negedge clk_in) if (take === 1'b1) take_count++;
  swr_rom_layer #(.REG_ID(ID), .RST_STD_CYC(16'h0640), .RST_LONG_CYC(16'h0BB8)) u_swr_rom_layer (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .line_in(bus_line), .line_out(line_lvl),
    .line_oe_out(dev_oe), .status_in(status), .mem_tx_in(tx), .mem_tx_take_out(take),
    .rx_data_out(rx_data), .rx_valid_out(rx_valid), .rx_ready_in(rx_ready),
    .mem_active_out(mem_act), .fast_speed_flag_out(fast), .resume_allowed_flag_out(rc),
    .link_reset_out(lrst), .general_view_out(gview), .refuse_out(refuse));
  swr_master_model u_master (.clk_in(clk_in), .line_in(bus_line), .master_low_out(m_low));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("checks=%0d fails=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  // 700 low cycles: a reset at fast speed, yet short of the long reset
  task automatic rst_fast();
    logic s;
    u_master.bus_reset(700, s);
    chk(64'(s), 64'h1);
  endtask : rst_fast
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_std_start();
    logic s;
    u_master.bus_reset(1700, s);
    chk(64'(s), 64'h1);
    u_master.send_byte(8'h3C);
    chk(64'({fast, mem_act}), 64'h3);
    u_master.set_speed(1'b1);
  endtask : t_std_start
  task automatic t_read_id();
    logic [63:0] v;
    rst_fast();
    u_master.send_byte(8'h33);
    u_master.read_id(v);
    chk(v, ID);
  endtask : t_read_id
  // select, then resume on the next access
  task automatic t_select(input logic [63:0] v, input logic ok);
    rst_fast();
    u_master.send_byte(8'h55);
    u_master.send_id(v);
    chk(64'({mem_act, rc}), ok ? 64'h3 : 64'h0);
    rst_fast();
    u_master.send_byte(8'hA5);
    chk(64'(mem_act), 64'(ok));
  endtask : t_select
  task automatic t_search();
    logic a, b;
    rst_fast();
    u_master.send_byte(8'hF0);
    for (int i = 0; i < 64; i++) begin
      u_master.slot(1'b1, a);
      u_master.slot(1'b1, b);
      chk(64'({a, b}), 64'({ID[i], ~ID[i]}));
      u_master.slot(ID[i], a);
    end
    chk(64'({mem_act, rc}), 64'h3);
  endtask : t_search
  // silent without alarm; with one, drops out on a wrong branch
  task automatic t_cond();
    logic a, b;
    status.alarm_flags = 8'hF8;
    rst_fast();
    u_master.send_byte(8'hEC);
    u_master.slot(1'b1, a);
    u_master.slot(1'b1, b);
    chk(64'({a, b}), 64'h3);
    status.alarm_flags = 8'h07;
    rst_fast();
    u_master.send_byte(8'hEC);
    u_master.slot(1'b1, a);
    u_master.slot(1'b1, b);
    chk(64'({a, b}), 64'({ID[0], ~ID[0]}));
    u_master.slot(~ID[0], a);
    u_master.slot(1'b1, a);
    u_master.slot(1'b1, b);
    chk(64'({a, b}), 64'h3);
    status.alarm_flags = 8'h00;
  endtask : t_cond
  task automatic t_mem();
    logic [7:0] d;
    int n;
    status.general_flags = 8'h12;
    rst_fast();
    u_master.send_byte(8'hCC);
    u_master.send_byte(8'h5A);
    for (int i = 0; i < 50 && rx_valid !== 1'b1; i++) @(negedge clk_in);
    chk(64'({rx_valid, rx_data}), 64'h15A);
    rx_ready = 1'b1;
    @(negedge clk_in);
    rx_ready = 1'b0;
    @(negedge clk_in);
    chk(64'(rx_valid), 64'h0);
    tx = '{en: 1'b1, data: 8'h3C};
    status.sample_busy = 1'b1;
    status.mission_running_flag = 1'b1;
    n = take_count;
    u_master.read_byte(d);
    chk(64'(d), 64'hFF);
    chk(64'(take_count - n), 64'h0);
    chk(64'({gview, refuse}), 64'h1FF);
    // core done: recover by resetting, re-addressing and repeating the read
    status = '{general_flags: 8'hED, wait_alarm: 1'b1, default: '0};
    rst_fast();
    u_master.send_byte(8'hCC);
    n = take_count;
    u_master.read_byte(d);
    chk(64'(d), 64'h3C);
    chk(64'(take_count - n), 64'h1);
    chk(64'({gview, refuse}), 64'h1DB);
    chk(64'(line_lvl), 64'h0);
    status = '0;
    tx = '0;
  endtask : t_mem
  task automatic t_long();
    logic s;
    u_master.set_speed(1'b0);
    u_master.bus_reset(3100, s);
    chk(64'({s, fast}), 64'h2);
  endtask : t_long
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence; reset held three cycles
  initial begin
    repeat (3) @(negedge clk_in);
    rst_n_in = 1'b1;
    t_std_start();
    t_read_id();
    t_select(ID, 1'b1);
    t_select(ID ^ 64'h0000_0100_0000_0000, 1'b0);
    t_search();
    t_cond();
    t_mem();
    t_long();
    conclude();
  end
  // hang guard
  initial begin
    repeat (150000) @(posedge clk_in);
    fail_count++;
    conclude();
  end
endmodule : single_wire_rom_layer_bench

// [test/swr_master_model.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// bus master model: it alone opens every slot
module swr_master_model (
  input wire logic clk_in,
  input wire logic line_in,
  output logic master_low_out
);
  int smp = 1500;
  int win = 3850;
  // pull low only; release leaves the pull-up to restore idle high
  initial master_low_out = 1'b0;
  task automatic set_speed(input logic fast);
    smp = fast ? 150 : 1500;
    win = fast ? 550 : 3850;
  endtask : set_speed
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask : wait_cyc
  // reset pulse, then watch the released line for presence
  task automatic bus_reset(input int low_cyc, output logic seen);
    seen = 1'b0;
    master_low_out = 1'b1;
    wait_cyc(low_cyc);
    master_low_out = 1'b0;
    for (int i = 0; i < win; i++) begin
      wait_cyc(1);
      if (line_in === 1'b0) seen = 1'b1;
    end
  endtask : bus_reset
  // a zero is held past the sample point but well short of a reset
  task automatic slot(input logic wr, output logic rd);
    rd = 1'b1;
    master_low_out = 1'b1;
    if (wr) begin
      wait_cyc(2);
      master_low_out = 1'b0;
      wait_cyc(smp / 2 - 2);
      rd = line_in;
      wait_cyc(smp / 2 + 5);
    end else begin
      wait_cyc(smp + 10);
      master_low_out = 1'b0;
      wait_cyc(5);
    end
  endtask : slot
  task automatic send_byte(input logic [7:0] b);
    logic r;
    for (int i = 0; i < 8; i++) slot(b[i], r);
  endtask : send_byte
  task automatic send_id(input logic [63:0] v);
    logic r;
    for (int i = 0; i < 64; i++) slot(v[i], r);
  endtask : send_id
  task automatic read_byte(output logic [7:0] b);
    logic r;
    for (int i = 0; i < 8; i++) begin
      slot(1'b1, r);
      b[i] = r;
    end
  endtask : read_byte
  task automatic read_id(output logic [63:0] v);
    logic r;
    for (int i = 0; i < 64; i++) begin
      slot(1'b1, r);
      v[i] = r;
    end
  endtask : read_id
endmodule : swr_master_model

// [test/swr_rom_layer_monitor.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// port-level checker for the rom layer
module swr_rom_layer_monitor #(
  parameter logic [15:0] RST_STD_CYC = 16'h1770,
  parameter logic [15:0] RST_LONG_CYC = 16'h86C4
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic line_in,
  input wire logic line_out,
  input wire logic line_oe_out,
  input wire swr_pkg::swr_status_s status_in,
  input wire logic [7:0] rx_data_out,
  input wire logic rx_valid_out,
  input wire logic rx_ready_in,
  input wire logic mem_active_out,
  input wire logic fast_speed_flag_out,
  input wire logic resume_allowed_flag_out,
  input wire logic link_reset_out,
  input wire logic [7:0] general_view_out,
  input wire logic refuse_out
);
  import swr_pkg::*;
  logic [15:0] low_run;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // master low stretch, saturating; the device's own presence pull does not count
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || line_in || line_oe_out) low_run <= 16'h0000;
    else if (low_run != 16'hFFFF) low_run <= low_run + 16'h0001;
  end
  property p_drain; line_out == 1'b0; endproperty
  a_drain: assert property (p_drain) else $error("data pin drives high");
  property p_pres; link_reset_out |-> !line_oe_out [*8] ##[1:800] line_oe_out; endproperty
  a_pres: assert property (p_pres) else $error("no presence after bus reset");
  property p_rst; $rose(line_in) && low_run > RST_STD_CYC |-> ##[1:3] link_reset_out; endproperty
  a_rst: assert property (p_rst) else $error("long low not taken as reset");
  property p_short; $rose(line_in) && low_run < 16'h0200 |=> !link_reset_out [*3]; endproperty
  a_short: assert property (p_short) else $error("short low taken as reset");
  property p_long; $rose(line_in) && low_run > RST_LONG_CYC |-> ##[1:3] !fast_speed_flag_out;
  endproperty
  a_long: assert property (p_long) else $error("fast speed kept after long reset");
  property p_view;
    1'b1 |=> general_view_out == ($past(status_in.sample_busy) ? 8'hFF
      : $past(status_in.general_flags));
  endproperty
  a_view: assert property (p_view) else $error("general view wrong");
  property p_refuse; status_in.mission_running_flag || status_in.wait_alarm |=> refuse_out;
  endproperty
  a_refuse: assert property (p_refuse) else $error("refuse not raised");
  property p_resume; $rose(resume_allowed_flag_out) |-> ##[0:2] mem_active_out; endproperty
  a_resume: assert property (p_resume) else $error("resume flag without selection");
  property p_drop; link_reset_out |-> ##[0:2] !mem_active_out; endproperty
  a_drop: assert property (p_drop) else $error("memory phase survives reset");
  property p_hold; rx_valid_out && !rx_ready_in |=> rx_valid_out && $stable(rx_data_out);
  endproperty
  a_hold: assert property (p_hold) else $error("fifo head changed unread");
endmodule : swr_rom_layer_monitor

bind swr_rom_layer swr_rom_layer_monitor #(
  .RST_STD_CYC(RST_STD_CYC),
  .RST_LONG_CYC(RST_LONG_CYC)
) u_swr_rom_layer_monitor (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .line_in(line_in), .line_out(line_out),
  .line_oe_out(line_oe_out), .status_in(status_in), .rx_data_out(rx_data_out),
  .rx_valid_out(rx_valid_out), .rx_ready_in(rx_ready_in), .mem_active_out(mem_active_out),
  .fast_speed_flag_out(fast_speed_flag_out),
  .resume_allowed_flag_out(resume_allowed_flag_out), .link_reset_out(link_reset_out),
  .general_view_out(general_view_out), .refuse_out(refuse_out)
);
